// ---- shared/ssc_regs.vh ----
`ifndef SSC_REGS_VH
`define SSC_REGS_VH
// command codes on the command port
`define SSC_CMD_OPC 4'h1
`define SSC_CMD_OPCQ 4'h2
`define SSC_CMD_RST 4'h3
`define SSC_CMD_SRE 4'h4
`define SSC_CMD_SREQ 4'h5
`define SSC_CMD_STBQ 4'h6
`define SSC_CMD_TSTQ 4'h7
`define SSC_CMD_WAI 4'h8
`define SSC_CMD_ABORT 4'h9
`define SSC_CMD_CLS 4'hA
`define SSC_CMD_ESE 4'hB
`define SSC_CMD_ESEQ 4'hC
`define SSC_CMD_ESRQ 4'hD
`define SSC_CMD_TRIGGER 4'hE
// register addresses
`define SSC_ADR_CMD 4'h0
`define SSC_ADR_STB 4'h1
`define SSC_ADR_SRE 4'h2
`define SSC_ADR_ESR 4'h3
`define SSC_ADR_ESE 4'h4
`define SSC_ADR_OUTQ 4'h5
`define SSC_ADR_CTRL 4'h6
`define SSC_ADR_ERR 4'h7
// bit positions
`define SSC_ESR_OPC 0
`define SSC_STB_QUES 3
`define SSC_STB_MAV 4
`define SSC_STB_ESB 5
`define SSC_STB_RQS 6
`define SSC_STB_OPER 7
// constants
`define SSC_ASCII_ONE 8'h31
`define SSC_ASCII_ZERO 8'h30
`define SSC_ERR_SELFTEST 8'h01
`define SSC_ST_IDLE 2'h0
`define SSC_ST_WAIT_TRIG 2'h1
`define SSC_ST_TRIGGERED 2'h2
`define SSC_CTRL_RST 8'h00
`endif

// ---- logic/ssc_core.v ----
// Local design decisions: the address map and the address-and-strobe port.
`timescale 1ns/1ns
`include "ssc_regs.vh"
// What this block does
// - opc command waits for idle operations, then sets event bit 0
// - while opc pends, further bus commands are held off
// - opc query waits for idle, then queues one ascii '1'
// - reset command restores settings to defaults, aborts pending work
// - reset keeps output queue, all enable masks, calibration data
// - eight-bit service-request mask; ones enable, zeros block bits
// - enabled status bits summarise into request bit 6
// - status bits change regardless of mask; mask gates request only
// - service-request mask query returns the stored mask
// - mask zero after power-up, untouched by reset command
// - status byte query returns byte, weight 64 when request pending
// - message-available sits at weight 16 of status byte
// - self-test query returns zero on pass, non-zero on fail
// - failed self-test leaves its error in the error queue
// - self-test changes no stored setting
// - wait command drops later commands until operations finish
// - abort leaves trigger states and enters idle
// - event summary bit 5 from enabled standard event bits
// - reading event register returns it, then clears it
// - clear-status empties event regs, error queue; masks kept
module ssc_core #(
   parameter QDEPTH = 4
)(
   // clock and reset
   input wire REF_CLK,
   input wire SYS_RST,
   // register port
   input wire [3:0] ADDR,
   input wire [7:0] WDATA,
   input wire WR,
   input wire RD,
   output reg [7:0] RDATA,
   // measurement engine
   input wire OP_BUSY,
   input wire SELFTEST_DONE,
   input wire SELFTEST_FAIL,
   input wire QUES_EVENT,
   input wire OPER_EVENT,
   output reg SELFTEST_START,
   output reg OP_ABORT,
   output reg [1:0] TRIG_STATE,
   output reg [7:0] SETTINGS,
   // status outputs
   output reg SRQ,
   output reg CMD_BUSY
);
   localparam S_READY = 2'h0;
   localparam S_DRAIN = 2'h1;
   localparam S_TEST = 2'h2;
   reg busy_s1_q, busy_q, stdone_s1_q, stdone_q, stfail_s1_q, stfail_q;
   reg ques_s1_q, ques_q, oper_s1_q, oper_q;
   reg [1:0] state_q;
   reg [3:0] pend_cmd_q;
   reg [7:0] sre_q, ese_q, esr_q, err_q;
   reg ques_bit_q, oper_bit_q;
   reg [2:0] cnt_q;
   wire cmd_wr = WR && (ADDR == `SSC_ADR_CMD);
   wire [3:0] cmd = WDATA[3:0];
   wire out_rd = RD && (ADDR == `SSC_ADR_OUTQ) && (cnt_q != 3'h0);
   reg [7:0] stb;
   wire rqs;
   wire esb = |(esr_q & ese_q);
   // status bits follow their sources whatever the mask holds
   always @*
   begin
      stb = 8'h00;
      stb[`SSC_STB_QUES] = ques_bit_q;
      stb[`SSC_STB_MAV] = (cnt_q != 3'h0);
      stb[`SSC_STB_ESB] = esb;
      stb[`SSC_STB_OPER] = oper_bit_q;
   end
   // the request bit never feeds itself back through the mask
   wire [7:0] rqs_keep = ~(8'h01 << `SSC_STB_RQS);
   assign rqs = |(stb & sre_q & rqs_keep);
   wire [7:0] stb_full = stb | ({7'h00, rqs} << `SSC_STB_RQS);
   // commands are only taken in the ready state
   wire take = cmd_wr && (state_q == S_READY);
   wire idle = !busy_q;
   reg push;
   reg [7:0] push_data;
   reg set_opc;
   always @*
   begin
      push = 1'b0;
      push_data = `SSC_ASCII_ZERO;
      set_opc = 1'b0;
      if (state_q == S_DRAIN && idle)
      begin
         if (pend_cmd_q == `SSC_CMD_OPCQ)
         begin
            push = 1'b1;
            push_data = `SSC_ASCII_ONE;
         end
         if (pend_cmd_q == `SSC_CMD_OPC)
            set_opc = 1'b1;
      end
      else if (state_q == S_TEST && stdone_q)
      begin
         push = 1'b1;
         push_data = stfail_q ? `SSC_ASCII_ONE : `SSC_ASCII_ZERO;
      end
      else if (take && cmd == `SSC_CMD_SREQ)
      begin
         push = 1'b1;
         push_data = sre_q;
      end
      else if (take && cmd == `SSC_CMD_STBQ)
      begin
         push = 1'b1;
         push_data = stb_full;
      end
      else if (take && cmd == `SSC_CMD_ESEQ)
      begin
         push = 1'b1;
         push_data = ese_q;
      end
      else if (take && cmd == `SSC_CMD_ESRQ)
      begin
         push = 1'b1;
         push_data = esr_q;
      end
   end
   // a full queue drops new responses rather than stall the engine
   wire do_push = push && (cnt_q != QDEPTH);
   // one slot per entry; a pop shifts every slot one place down
   wire [8*QDEPTH-1:0] slot_w;
   wire [8*QDEPTH+7:0] slot_up = {8'h00, slot_w};
   wire [2:0] wr_slot = out_rd ? cnt_q - 3'h1 : cnt_q;
   genvar g;
   generate
      for (g = 0; g < QDEPTH; g = g + 1)
      begin : g_slot
         reg [7:0] slot_q;
         assign slot_w[8*g+7:8*g] = slot_q;
         always @(posedge REF_CLK or posedge SYS_RST)
         begin
            if (SYS_RST)
               slot_q <= 8'h00;
            else if (do_push && wr_slot == g)
               slot_q <= push_data;
            else if (out_rd)
               slot_q <= slot_up[8*g+15:8*g+8];
         end
      end
   endgenerate
   always @(posedge REF_CLK or posedge SYS_RST)
   begin
      if (SYS_RST)
      begin
         busy_s1_q <= 1'b0;
         busy_q <= 1'b0;
         stdone_s1_q <= 1'b0;
         stdone_q <= 1'b0;
         stfail_s1_q <= 1'b0;
         stfail_q <= 1'b0;
         ques_s1_q <= 1'b0;
         ques_q <= 1'b0;
         oper_s1_q <= 1'b0;
         oper_q <= 1'b0;
      end
      else
      begin
         // engine lines are unclocked here: two flops each
         busy_s1_q <= OP_BUSY;
         busy_q <= busy_s1_q;
         stdone_s1_q <= SELFTEST_DONE;
         stdone_q <= stdone_s1_q;
         stfail_s1_q <= SELFTEST_FAIL;
         stfail_q <= stfail_s1_q;
         ques_s1_q <= QUES_EVENT;
         ques_q <= ques_s1_q;
         oper_s1_q <= OPER_EVENT;
         oper_q <= oper_s1_q;
      end
   end
   always @(posedge REF_CLK or posedge SYS_RST)
   begin
      if (SYS_RST)
      begin
         state_q <= S_READY;
         pend_cmd_q <= 4'h0;
         sre_q <= 8'h00;
         ese_q <= 8'h00;
         esr_q <= 8'h00;
         err_q <= 8'h00;
         ques_bit_q <= 1'b0;
         oper_bit_q <= 1'b0;
         cnt_q <= 3'h0;
         RDATA <= 8'h00;
         SELFTEST_START <= 1'b0;
         OP_ABORT <= 1'b0;
         TRIG_STATE <= `SSC_ST_IDLE;
         SETTINGS <= `SSC_CTRL_RST;
         SRQ <= 1'b0;
         CMD_BUSY <= 1'b0;
      end
      else
      begin
         SELFTEST_START <= 1'b0;
         OP_ABORT <= 1'b0;
         // events are set after clears so a same-cycle event wins
         if (take && cmd == `SSC_CMD_CLS)
         begin
            esr_q <= 8'h00;
            err_q <= 8'h00;
            ques_bit_q <= 1'b0;
            oper_bit_q <= 1'b0;
         end
         if (RD && ADDR == `SSC_ADR_ESR)
            esr_q <= 8'h00;
         if (take && cmd == `SSC_CMD_ESRQ)
            esr_q <= 8'h00;
         if (set_opc)
            esr_q[`SSC_ESR_OPC] <= 1'b1;
         if (ques_q)
            ques_bit_q <= 1'b1;
         if (oper_q)
            oper_bit_q <= 1'b1;
         if (WR && ADDR == `SSC_ADR_SRE)
            sre_q <= WDATA;
         if (WR && ADDR == `SSC_ADR_ESE)
            ese_q <= WDATA;
         if (WR && ADDR == `SSC_ADR_CTRL && state_q == S_READY)
            SETTINGS <= WDATA;
         case (state_q)
            S_READY:
            begin
               if (take)
               begin
                  case (cmd)
                     `SSC_CMD_OPC, `SSC_CMD_OPCQ, `SSC_CMD_WAI:
                     begin
                        state_q <= S_DRAIN;
                        pend_cmd_q <= cmd;
                     end
                     `SSC_CMD_RST:
                     begin
                        // masks, queue and calibration left alone
                        SETTINGS <= `SSC_CTRL_RST;
                        OP_ABORT <= 1'b1;
                        TRIG_STATE <= `SSC_ST_IDLE;
                     end
                     `SSC_CMD_SRE: sre_q <= WDATA;
                     `SSC_CMD_TSTQ:
                     begin
                        // settings are not touched here
                        state_q <= S_TEST;
                        SELFTEST_START <= 1'b1;
                     end
                     `SSC_CMD_ABORT:
                     begin
                        TRIG_STATE <= `SSC_ST_IDLE;
                        OP_ABORT <= 1'b1;
                     end
                     `SSC_CMD_TRIGGER:
                        TRIG_STATE <= `SSC_ST_WAIT_TRIG;
                     default: ;
                  endcase
               end
            end
            S_DRAIN:
               if (idle)
                  state_q <= S_READY;
            S_TEST:
               if (stdone_q)
               begin
                  state_q <= S_READY;
                  // a failed test leaves its code for the error read
                  if (stfail_q)
                     err_q <= `SSC_ERR_SELFTEST;
               end
            default: state_q <= S_READY;
         endcase
         // queue fill count; the slots themselves live in g_slot
         if (do_push && !out_rd)
            cnt_q <= cnt_q + 3'h1;
         else if (out_rd && !do_push)
            cnt_q <= cnt_q - 3'h1;
         // read data registered from whatever address stands
         case (ADDR)
            `SSC_ADR_STB: RDATA <= stb_full;
            `SSC_ADR_SRE: RDATA <= sre_q;
            `SSC_ADR_ESR: RDATA <= esr_q;
            `SSC_ADR_ESE: RDATA <= ese_q;
            `SSC_ADR_OUTQ: RDATA <= (cnt_q != 3'h0) ? slot_w[7:0] : 8'h00;
            `SSC_ADR_CTRL: RDATA <= SETTINGS;
            `SSC_ADR_ERR: RDATA <= err_q;
            `SSC_ADR_CMD: RDATA <= {6'h00, state_q};
            default: RDATA <= 8'h00;
         endcase
         SRQ <= rqs;
         // busy mirrors the state entered at this edge, with no lag
         CMD_BUSY <= (state_q == S_DRAIN && !idle)
            || (state_q == S_TEST && !stdone_q)
            || (take && (cmd == `SSC_CMD_OPC || cmd == `SSC_CMD_OPCQ
            || cmd == `SSC_CMD_WAI || cmd == `SSC_CMD_TSTQ));
      end
   end
endmodule // ssc_core

// ---- sim/ssc_eng_model.sv ----
`timescale 1ns/1ns
module ssc_eng_model(
   // clock and reset
   input wire clk,
   input wire rst,
   // control from bench and device
   input wire go,
   input wire [7:0] busy_len,
   input wire start,
   input wire fail_en,
   // engine status
   output reg busy,
   output reg done,
   output reg fail
);
   reg [7:0] cnt_q;
   reg [3:0] st_q;
   always @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         cnt_q <= 8'h00;
         st_q <= 4'h0;
      end
      else
      begin
         if (go)
            cnt_q <= busy_len;
         else if (cnt_q != 8'h00)
            cnt_q <= cnt_q - 8'h01;
         if (start)
            st_q <= 4'h8;
         else if (st_q != 4'h0)
            st_q <= st_q - 4'h1;
      end
   end
   // done held 3 cycles so the 2 FF sync sees it
   always @*
   begin
      busy = cnt_q != 8'h00;
      done = st_q != 4'h0 && st_q < 4'h4;
      // fail is meaningless outside done: show the inverse
      fail = done ? fail_en : !fail_en;
   end
endmodule // ssc_eng_model

// ---- sim/ssc_core_asserts.sv ----
`timescale 1ns/1ns
`include "ssc_regs.vh"
module ssc_chk(
   input wire REF_CLK,
   input wire SYS_RST,
   input wire [3:0] ADDR,
   input wire [7:0] WDATA,
   input wire WR,
   input wire RD,
   input wire [7:0] RDATA,
   input wire OP_BUSY,
   input wire SELFTEST_DONE,
   input wire SELFTEST_FAIL,
   input wire QUES_EVENT,
   input wire OPER_EVENT,
   input wire SELFTEST_START,
   input wire OP_ABORT,
   input wire [1:0] TRIG_STATE,
   input wire [7:0] SETTINGS,
   input wire SRQ,
   input wire CMD_BUSY
);
   default clocking @(posedge REF_CLK); endclocking
   default disable iff (SYS_RST);
   wire cmd_ok = WR && ADDR == `SSC_ADR_CMD && !CMD_BUSY;
   wire [3:0] code = WDATA[3:0];
   property p_rst;
      cmd_ok && code == `SSC_CMD_RST |=> OP_ABORT && SETTINGS == 8'h00;
   endproperty
   a_rst: assert property (p_rst) else $error("reset cmd");
   property p_abort;
      cmd_ok && code == `SSC_CMD_ABORT |=> TRIG_STATE == `SSC_ST_IDLE;
   endproperty
   a_abort: assert property (p_abort) else $error("abort");
   property p_tst;
      cmd_ok && code == `SSC_CMD_TSTQ |=> SELFTEST_START;
   endproperty
   a_tst: assert property (p_tst) else $error("self-test start");
   property p_keep;
      SELFTEST_START && !WR |=> $stable(SETTINGS);
   endproperty
   a_keep: assert property (p_keep) else $error("settings moved");
   property p_opc;
      OP_BUSY [*3] ##0 cmd_ok && code == `SSC_CMD_OPC |=> CMD_BUSY [*2];
   endproperty
   a_opc: assert property (p_opc) else $error("opc no holdoff");
   property p_wai;
      OP_BUSY [*3] ##0 cmd_ok && code == `SSC_CMD_WAI |=> CMD_BUSY [*2];
   endproperty
   a_wai: assert property (p_wai) else $error("wai no holdoff");
   property p_sre;
      WR && ADDR == `SSC_ADR_SRE ##1 !WR ##1 RD && ADDR == `SSC_ADR_SRE
         |=> RDATA == $past(WDATA, 3);
   endproperty
   a_sre: assert property (p_sre) else $error("mask readback");
   property p_stb;
      RD && ADDR == `SSC_ADR_STB |=> RDATA[`SSC_STB_RQS] == SRQ;
   endproperty
   a_stb: assert property (p_stb) else $error("rqs bit");
   c_srq: cover property (SRQ);
   c_st: cover property (SELFTEST_START);
   c_hold: cover property (CMD_BUSY ##1 !CMD_BUSY);
endmodule // ssc_chk
bind ssc_core ssc_chk u_chk(.REF_CLK(REF_CLK), .SYS_RST(SYS_RST),
   .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
   .OP_BUSY(OP_BUSY), .SELFTEST_DONE(SELFTEST_DONE),
   .SELFTEST_FAIL(SELFTEST_FAIL), .QUES_EVENT(QUES_EVENT),
   .OPER_EVENT(OPER_EVENT), .SELFTEST_START(SELFTEST_START),
   .OP_ABORT(OP_ABORT), .TRIG_STATE(TRIG_STATE), .SETTINGS(SETTINGS),
   .SRQ(SRQ), .CMD_BUSY(CMD_BUSY));

// ---- sim/tb_top.sv ----
`timescale 1ns/1ns
`include "ssc_regs.vh"
module tb_top;
   reg clk = 1'b0;
   reg rst = 1'b1;
   reg [3:0] addr = 4'h0;
   reg [7:0] wdata = 8'h00;
   reg wr = 1'b0;
   reg rd = 1'b0;
   reg go = 1'b0;
   reg fail_en = 1'b0;
   reg ques = 1'b0;
   reg oper = 1'b0;
   wire [7:0] rdata;
   wire [7:0] sett;
   wire [1:0] trig;
   wire busy, done, fail, st_go, abrt, srq, cbusy;
   integer n_mismatch = 0;
   integer n_tests = 0;
   integer cyc = 0;
   always #25 clk = ~clk;
   ssc_core dut(.REF_CLK(clk), .SYS_RST(rst), .ADDR(addr), .WDATA(wdata),
      .WR(wr), .RD(rd), .RDATA(rdata), .OP_BUSY(busy),
      .SELFTEST_DONE(done), .SELFTEST_FAIL(fail), .QUES_EVENT(ques),
      .OPER_EVENT(oper), .SELFTEST_START(st_go), .OP_ABORT(abrt),
      .TRIG_STATE(trig), .SETTINGS(sett), .SRQ(srq), .CMD_BUSY(cbusy));
   ssc_eng_model eng(.clk(clk), .rst(rst), .go(go), .busy_len(8'h14),
      .start(st_go), .fail_en(fail_en), .busy(busy), .done(done),
      .fail(fail));
   task wrap_up;
   begin
      $display("tests %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   end
   endtask
   task chk(input [7:0] got, input [7:0] exp);
   begin
      n_tests = n_tests + 1;
      if (got !== exp)
      begin
         n_mismatch = n_mismatch + 1;
         $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
      end
   end
   endtask
   task wreg(input [3:0] a, input [7:0] d);
   begin
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      #1;
   end
   endtask
   task rreg(input [3:0] a, input [7:0] exp);
   begin
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 chk(rdata, exp);
   end
   endtask
   task cmd(input [3:0] c);
      wreg(`SSC_ADR_CMD, {4'h0, c});
   endtask
   // polls busy, then lets the queue push and syncs land
   task idle;
      integer i;
   begin
      for (i = 0; i < 200 && cbusy !== 1'b0; i = i + 1)
      begin
         @(posedge clk);
         #1;
      end
      repeat (4) @(posedge clk);
   end
   endtask
   task pend;
   begin
      @(posedge clk);
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      repeat (4) @(posedge clk);
   end
   endtask
   task t_mask;
   begin
      rreg(`SSC_ADR_SRE, 8'h00);
      wreg(`SSC_ADR_SRE, 8'h10);
      rreg(`SSC_ADR_SRE, 8'h10);
      cmd(`SSC_CMD_SREQ);
      idle;
      rreg(`SSC_ADR_OUTQ, 8'h10);
      cmd(`SSC_CMD_OPCQ);
      idle;
      rreg(`SSC_ADR_STB, 8'h50);
      chk({7'h00, srq}, 8'h01);
      wreg(`SSC_ADR_SRE, 8'h00);
      rreg(`SSC_ADR_STB, 8'h10);
      rreg(`SSC_ADR_OUTQ, `SSC_ASCII_ONE);
      $display("mask done");
   end
   endtask
   task t_reset;
   begin
      cmd(`SSC_CMD_SRE);
      rreg(`SSC_ADR_SRE, 8'h04);
      wreg(`SSC_ADR_SRE, 8'h20);
      wreg(`SSC_ADR_ESE, 8'h01);
      wreg(`SSC_ADR_CTRL, 8'h5A);
      cmd(`SSC_CMD_OPCQ);
      idle;
      cmd(`SSC_CMD_RST);
      chk({7'h00, abrt}, 8'h01);
      idle;
      chk(sett, 8'h00);
      rreg(`SSC_ADR_SRE, 8'h20);
      rreg(`SSC_ADR_ESE, 8'h01);
      rreg(`SSC_ADR_OUTQ, `SSC_ASCII_ONE);
      cmd(`SSC_CMD_ESEQ);
      rreg(`SSC_ADR_OUTQ, 8'h01);
      $display("reset done");
   end
   endtask
   task t_sync;
   begin
      pend;
      cmd(`SSC_CMD_OPC);
      chk({7'h00, cbusy}, 8'h01);
      idle;
      rreg(`SSC_ADR_STB, 8'h60);
      rreg(`SSC_ADR_ESR, 8'h01);
      rreg(`SSC_ADR_ESR, 8'h00);
      cmd(`SSC_CMD_OPC);
      idle;
      cmd(`SSC_CMD_ESRQ);
      rreg(`SSC_ADR_OUTQ, 8'h01);
      rreg(`SSC_ADR_ESR, 8'h00);
      pend;
      cmd(`SSC_CMD_WAI);
      cmd(`SSC_CMD_SREQ);
      idle;
      rreg(`SSC_ADR_STB, 8'h00);
      $display("sync done");
   end
   endtask
   task t_test;
   begin
      cmd(`SSC_CMD_TRIGGER);
      chk({6'h00, trig}, 8'h01);
      cmd(`SSC_CMD_ABORT);
      chk({6'h00, trig}, 8'h00);
      wreg(`SSC_ADR_CTRL, 8'h3C);
      cmd(`SSC_CMD_TSTQ);
      chk({7'h00, st_go}, 8'h01);
      idle;
      rreg(`SSC_ADR_OUTQ, `SSC_ASCII_ZERO);
      fail_en <= 1'b1;
      cmd(`SSC_CMD_TSTQ);
      idle;
      rreg(`SSC_ADR_OUTQ, `SSC_ASCII_ONE);
      rreg(`SSC_ADR_ERR, `SSC_ERR_SELFTEST);
      chk(sett, 8'h3C);
      $display("self-test done");
   end
   endtask
   task t_clear;
   begin
      @(posedge clk);
      ques <= 1'b1;
      oper <= 1'b1;
      @(posedge clk);
      ques <= 1'b0;
      oper <= 1'b0;
      repeat (4) @(posedge clk);
      rreg(`SSC_ADR_STB, 8'h88);
      cmd(`SSC_CMD_CLS);
      idle;
      rreg(`SSC_ADR_STB, 8'h00);
      rreg(`SSC_ADR_SRE, 8'h20);
      rreg(`SSC_ADR_ESE, 8'h01);
      rreg(`SSC_ADR_ERR, 8'h00);
      $display("clear done");
   end
   endtask
   always @(posedge clk)
   begin
      cyc = cyc + 1;
      if (cyc == 4000)
      begin
         n_mismatch = n_mismatch + 1;
         wrap_up;
      end
   end
   initial
   begin
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      t_mask;
      t_reset;
      t_sync;
      t_test;
      t_clear;
      wrap_up;
   end
endmodule // tb_top
